// ==== common/bmg_cfg.svh ====
// offsets, field positions, reset values and step limits of the burst gate
`ifndef BMG_CFG_SVH
`define BMG_CFG_SVH
`define BMG_OFS_CTRL 8'h00
`define BMG_OFS_EN 8'h04
`define BMG_OFS_CYC 8'h08
`define BMG_OFS_DLY 8'h0c
`define BMG_OFS_STAT 8'h10
`define BMG_OFS_ERR 8'h14
`define BMG_OFS_BITS 8'h18
`define BMG_CTRL_BURST 0
`define BMG_CTRL_SRC 1
`define BMG_CTRL_MAN 3
`define BMG_CTRL_SLOT 4
`define BMG_CTRL_PAT 6
`define BMG_CTRL_RST 9'h000
`define BMG_EN_RST 25'h0000064
`define BMG_CYC_RST 25'h00000c8
`define BMG_DLY_RST 28'h0000000
`define BMG_PAT_LAST_BURST 3'h3
`define BMG_EN_MIN 28'd100
`define BMG_EN_MAX_INT 28'd16777212
`define BMG_EN_MAX_TRG 28'd16777215
`define BMG_CYC_MIN 28'd200
`define BMG_CYC_MAX 28'd16777216
`define BMG_GAP_STEPS 28'd4
`define BMG_DLY_MAX_INT 28'd134217728
`define BMG_DLY_MAX_EXT 28'd134217724
`define BMG_EN_SHIFT 4'd7
`define BMG_DLY_SHIFT 4'd4
`define BMG_DLY_DEPTH 3'd4
`endif

// ==== common/bmg_pkg.sv ====
// types shared by the burst gate modules
package bmg_pkg;
    typedef enum logic [2:0] {
        st_idle = 3'b001,
        st_open = 3'b010,
        st_gap = 3'b100
    } bmg_state_e;
    typedef enum logic [1:0] {
        src_int = 2'b00,
        src_trg = 2'b01,
        src_ext = 2'b10
    } bmg_src_e;
    typedef logic [34:0] bmg_bits_t;
endpackage

// ==== verilog/bmg_delay.sv ====
// edge-timestamp delay line that shifts the gate by a bit count
`timescale 1ns/1ps
`include "bmg_cfg.svh"
module bmg_delay (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic gate_in,
    input wire bmg_pkg::bmg_bits_t dly_bits,
    output logic gate_out,
    output logic ovf
);
    logic [35:0] now_q, now_d;
    logic [36:0] mem_q [4];
    logic [36:0] mem_d [4];
    logic [1:0] rd_q, rd_d, wr_q, wr_d;
    logic [2:0] cnt_q, cnt_d;
    logic in_prev_q, out_q, out_d, ovf_q, ovf_d;
    logic push, full, pop;
    logic [35:0] late;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // only edges are stored, so a delay of billions of bits needs four words
    always_comb
    begin
        push = gate_in != in_prev_q;
        full = cnt_q == `BMG_DLY_DEPTH;
        // a head whose time has passed still pops, so a shorter delay cannot strand the queue
        late = 36'(now_q - mem_q[rd_q][35:0]);
        pop = (cnt_q != 3'h0) && !late[35];
        now_d = 36'(now_q + 36'h1);
        mem_d = mem_q;
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        out_d = out_q;
        ovf_d = push && full; // edge lost: gaps too short for the queue
        if (push && !full)
        begin
            mem_d[wr_q] = {gate_in, 36'(now_q + {1'b0, dly_bits} + 36'h1)};
            wr_d = 2'(wr_q + 2'h1);
        end
        if (pop)
        begin
            out_d = mem_q[rd_q][36]; // level applied when its time comes
            rd_d = 2'(rd_q + 2'h1);
        end
        cnt_d = 3'(cnt_q + {2'h0, push && !full} - {2'h0, pop});
    end

    // registers of the delay line
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            now_q <= '0;
            for (int i = 0; i < 4; i++)
                mem_q[i] <= '0;
            rd_q <= '0;
            wr_q <= '0;
            cnt_q <= '0;
            in_prev_q <= 1'b0;
            out_q <= 1'b0;
            ovf_q <= 1'b0;
        end
        else
        begin
            now_q <= now_d;
            mem_q <= mem_d;
            rd_q <= rd_d;
            wr_q <= wr_d;
            cnt_q <= cnt_d;
            in_prev_q <= gate_in;
            out_q <= out_d;
            ovf_q <= ovf_d;
        end
    end

    assign gate_out = out_q;
    assign ovf = ovf_q;

    sequence s_lone_edge;
        dly_bits == '0 && gate_in != in_prev_q && cnt_q == 3'h0;
    endsequence
    property p_zero_delay;
        s_lone_edge |-> ##2 gate_out == $past(gate_in, 2);
    endproperty
    a_zero_delay: assert property (p_zero_delay) else $error("zero delay latency wrong");
    property p_out_on_due;
        $changed(out_q) |-> $past(pop);
    endproperty
    a_out_on_due: assert property (p_out_on_due) else $error("gate moved off schedule");
    property p_depth;
        cnt_q <= `BMG_DLY_DEPTH;
    endproperty
    a_depth: assert property (p_depth) else $error("delay queue overfilled");
endmodule

// ==== verilog/bmg_gate.sv ====
// burst measurement gate with apb registers and error counting
// What this block does
// - offers repeat and burst reception; burst only for prbs, zero-sub, data, mixed
// - internal source builds the measuring gate itself without external signal
// - external trigger starts a period; gate stays open for programmed length
// - external enable input sets both start and length of each period
// - external enable is the mode to pick when burst timing varies
// - gate-to-pattern delay is automatic or a manual bit count
// - single slot: delay to 2^31 bits internal, less 64 otherwise, 16-bit steps
// - two slots internal: delay up to 2^32 bits in 32-bit steps
// - four slots: delay up to 2^33 bits, less 256 otherwise, 64-bit steps
// - internal and trigger sources use a programmed enable period in bits
// - internal source uses a programmed burst cycle length in bits
// - single slot: enable 12800 up, cycle 25600 up, 128-bit steps
// - trigger enable reaches higher; two slots double minima and steps
// - at least 512 disabled bits between enable end and next cycle, scaled by slots
// - four slots: enable from 51200, cycle 102400 to 2^33, 512-bit steps
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "bmg_cfg.svh"
module bmg_gate (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_bit,
    input wire logic ref_bit,
    input wire logic aux_in,
    output logic cmp_en,
    output logic err_pulse
);
    logic [8:0] ctrl_q, ctrl_d;
    logic [24:0] en_q, en_d, cyc_q, cyc_d;
    logic [27:0] dly_q, dly_d;
    logic [31:0] err_cnt_q, err_cnt_d, bit_cnt_q, bit_cnt_d;
    logic ovf_q, ovf_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d;
    bmg_pkg::bmg_state_e st_q, st_d;
    bmg_pkg::bmg_bits_t cnt_q, cnt_d;
    logic aux_prev_q, gate_raw_q, gate_raw_d;
    logic cmp_en_q, cmp_en_d, err_q, err_d;
    logic access, wr, mapped, cfg_wr;
    logic burst_act, manual;
    bmg_pkg::bmg_src_e src;
    logic [1:0] shf;
    logic [27:0] en_c, cyc_c, dly_c;
    bmg_pkg::bmg_bits_t en_bits, gap_bits, dly_bits;
    logic gate_dly, dly_ovf;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // lower bound wins over any value below it, so an internal cycle never undercuts enable plus gap
    function automatic logic [27:0] clampv(input logic [27:0] v, input logic [27:0] lo,
                                           input logic [27:0] hi);
        clampv = v;
        if (v > hi)
            clampv = hi;
        if (v < lo)
            clampv = lo;
    endfunction

    // a step count scaled to bits; step size doubles per slot doubling
    function automatic bmg_pkg::bmg_bits_t to_bits(input logic [27:0] steps,
                                                   input logic [3:0] sh);
        to_bits = {7'h00, steps} << sh;
    endfunction

    // control decode
    assign src = bmg_pkg::bmg_src_e'(ctrl_q[`BMG_CTRL_SRC +: 2]);
    assign manual = ctrl_q[`BMG_CTRL_MAN];
    assign shf = (ctrl_q[`BMG_CTRL_SLOT +: 2] > 2'h2) ? 2'h2 : ctrl_q[`BMG_CTRL_SLOT +: 2];
    assign burst_act = ctrl_q[`BMG_CTRL_BURST] &&
                       (ctrl_q[`BMG_CTRL_PAT +: 3] <= `BMG_PAT_LAST_BURST);

    // limits are the same in steps for every slot count; only step size scales
    always_comb
    begin
        en_c = clampv({3'h0, en_q}, `BMG_EN_MIN,
                      (src == bmg_pkg::src_trg) ? `BMG_EN_MAX_TRG : `BMG_EN_MAX_INT);
        cyc_c = clampv({3'h0, cyc_q}, 28'(en_c + `BMG_GAP_STEPS) > `BMG_CYC_MIN ?
                       28'(en_c + `BMG_GAP_STEPS) : `BMG_CYC_MIN, `BMG_CYC_MAX);
        dly_c = clampv(dly_q, 28'h0000000,
                       (src == bmg_pkg::src_int) ? `BMG_DLY_MAX_INT : `BMG_DLY_MAX_EXT);
        en_bits = to_bits(en_c, 4'(`BMG_EN_SHIFT + {2'h0, shf}));
        gap_bits = 35'(to_bits(cyc_c, 4'(`BMG_EN_SHIFT + {2'h0, shf})) - en_bits);
        dly_bits = manual ? to_bits(dly_c, 4'(`BMG_DLY_SHIFT + {2'h0, shf})) : '0;
    end

    // apb slave: one wait state, data and writes land on the pready edge
    always_comb
    begin
        access = psel && penable;
        wr = access && pready_q && pwrite;
        mapped = paddr <= `BMG_OFS_BITS && paddr[1:0] == 2'h0;
        cfg_wr = wr && paddr == `BMG_OFS_CTRL;
        pready_d = access && !pready_q;
        pslverr_d = access && !pready_q && !mapped;
        prdata_d = prdata_q;
        if (access && !pready_q)
        begin
            case (paddr)
                `BMG_OFS_CTRL: prdata_d = {23'h0, ctrl_q};
                `BMG_OFS_EN: prdata_d = {7'h0, en_q};
                `BMG_OFS_CYC: prdata_d = {7'h0, cyc_q};
                `BMG_OFS_DLY: prdata_d = {4'h0, dly_q};
                `BMG_OFS_STAT: prdata_d = {26'h0, ovf_q, cmp_en_q, gate_raw_q, st_q};
                `BMG_OFS_ERR: prdata_d = err_cnt_q;
                `BMG_OFS_BITS: prdata_d = bit_cnt_q;
                default: prdata_d = 32'h00000000;
            endcase
        end
        ctrl_d = cfg_wr ? pwdata[8:0] : ctrl_q;
        en_d = (wr && paddr == `BMG_OFS_EN) ? pwdata[24:0] : en_q;
        cyc_d = (wr && paddr == `BMG_OFS_CYC) ? pwdata[24:0] : cyc_q;
        dly_d = (wr && paddr == `BMG_OFS_DLY) ? pwdata[27:0] : dly_q;
        // overflow sticks; a new one in the clearing cycle still sets it
        ovf_d = ((wr && paddr == `BMG_OFS_STAT && pwdata[5]) ? 1'b0 : ovf_q) | dly_ovf;
    end

    // register file
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_q <= `BMG_CTRL_RST;
            en_q <= `BMG_EN_RST;
            cyc_q <= `BMG_CYC_RST;
            dly_q <= `BMG_DLY_RST;
            ovf_q <= 1'b0;
            prdata_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            en_q <= en_d;
            cyc_q <= cyc_d;
            dly_q <= dly_d;
            ovf_q <= ovf_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // gate sequencer; any control write restarts it from idle
    always_comb
    begin
        st_d = st_q;
        cnt_d = 35'(cnt_q + 35'h1);
        case (st_q)
            bmg_pkg::st_idle:
            begin
                cnt_d = '0;
                if (src == bmg_pkg::src_int)
                    st_d = bmg_pkg::st_open;
                else if (src == bmg_pkg::src_trg && aux_in && !aux_prev_q)
                    st_d = bmg_pkg::st_open;
            end
            bmg_pkg::st_open:
            begin
                if (cnt_q == 35'(en_bits - 35'h1))
                begin
                    cnt_d = '0; // retriggers while open are ignored
                    st_d = (src == bmg_pkg::src_int) ? bmg_pkg::st_gap : bmg_pkg::st_idle;
                end
            end
            bmg_pkg::st_gap:
            begin
                if (cnt_q == 35'(gap_bits - 35'h1))
                begin
                    cnt_d = '0;
                    st_d = bmg_pkg::st_open;
                end
            end
            default:
            begin
                cnt_d = '0;
                st_d = bmg_pkg::st_idle;
            end
        endcase
        if (!burst_act || src == bmg_pkg::src_ext || cfg_wr)
        begin
            cnt_d = '0;
            st_d = bmg_pkg::st_idle;
        end
        // external enable passes the auxiliary level straight through
        gate_raw_d = (src == bmg_pkg::src_ext) ? aux_in : (st_d == bmg_pkg::st_open);
    end

    // measured bits and errors only while the delayed gate is open in burst mode; repeat mode counts every bit
    always_comb
    begin
        cmp_en_d = !burst_act || gate_dly;
        err_d = cmp_en_q && (rx_bit ^ ref_bit);
        err_cnt_d = 32'(err_cnt_q + {31'h0, err_d});
        bit_cnt_d = 32'(bit_cnt_q + {31'h0, cmp_en_q});
        if (wr && paddr == `BMG_OFS_ERR)
        begin
            err_cnt_d = {31'h0, err_d}; // clear loses no error of this cycle
            bit_cnt_d = {31'h0, cmp_en_q};
        end
    end

    // gate and measurement registers
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_q <= bmg_pkg::st_idle;
            cnt_q <= '0;
            aux_prev_q <= 1'b0;
            gate_raw_q <= 1'b0;
            cmp_en_q <= 1'b0;
            err_q <= 1'b0;
            err_cnt_q <= '0;
            bit_cnt_q <= '0;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            aux_prev_q <= aux_in;
            gate_raw_q <= gate_raw_d;
            cmp_en_q <= cmp_en_d;
            err_q <= err_d;
            err_cnt_q <= err_cnt_d;
            bit_cnt_q <= bit_cnt_d;
        end
    end

    // gate-to-pattern delay line
    bmg_delay u_delay (
        .clk(clk),
        .reset_n(reset_n),
        .gate_in(gate_raw_q),
        .dly_bits(dly_bits),
        .gate_out(gate_dly),
        .ovf(dly_ovf)
    );

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign cmp_en = cmp_en_q;
    assign err_pulse = err_q;

    sequence s_trig_fire;
        burst_act && src == bmg_pkg::src_trg && st_q == bmg_pkg::st_idle && aux_in &&
            !aux_prev_q && !cfg_wr;
    endsequence
    sequence s_open_end;
        burst_act && !cfg_wr && st_q == bmg_pkg::st_open && cnt_q == 35'(en_bits - 35'h1);
    endsequence
    property p_repeat_cmp;
        !burst_act |=> cmp_en_q;
    endproperty
    a_repeat_cmp: assert property (p_repeat_cmp) else $error("repeat mode not comparing");
    property p_int_start;
        burst_act && src == bmg_pkg::src_int && st_q == bmg_pkg::st_idle && !cfg_wr
            |=> gate_raw_q;
    endproperty
    a_int_start: assert property (p_int_start) else $error("internal gate did not open");
    property p_trig_start;
        s_trig_fire |=> st_q == bmg_pkg::st_open && gate_raw_q && cnt_q == '0;
    endproperty
    a_trig_start: assert property (p_trig_start) else $error("trigger did not open gate");
    property p_open_end;
        s_open_end |=> !gate_raw_q || src == bmg_pkg::src_ext;
    endproperty
    a_open_end: assert property (p_open_end) else $error("gate outlived enable period");
    property p_ext_enable;
        src == bmg_pkg::src_ext |=> gate_raw_q == $past(aux_in);
    endproperty
    a_ext_enable: assert property (p_ext_enable) else $error("gate not following aux");
    property p_en_range;
        en_c >= `BMG_EN_MIN &&
            en_c <= ((src == bmg_pkg::src_trg) ? `BMG_EN_MAX_TRG : `BMG_EN_MAX_INT);
    endproperty
    a_en_range: assert property (p_en_range) else $error("enable period out of range");
    property p_gap;
        src == bmg_pkg::src_int |-> // only the internal source runs a burst cycle
            cyc_c >= 28'(en_c + `BMG_GAP_STEPS) && cyc_c <= `BMG_CYC_MAX;
    endproperty
    a_gap: assert property (p_gap) else $error("disabled gap too short");
    property p_auto_zero;
        !manual |-> dly_bits == '0;
    endproperty
    a_auto_zero: assert property (p_auto_zero) else $error("auto delay not zero");
    property p_no_count_closed;
        !cmp_en_q && !(wr && paddr == `BMG_OFS_ERR) |=> $stable(bit_cnt_q) && $stable(err_cnt_q);
    endproperty
    a_no_count_closed: assert property (p_no_count_closed) else $error("counted while closed");
endmodule

// ==== tb/bmg_far_end.sv ====
// far-end model: the unit under test sending the pattern, plus the auxiliary gate source
`timescale 1ns/1ps
module bmg_far_end (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic pat_bit,
    input wire logic err_req,
    input wire logic aux_req,
    output logic rx_bit,
    output logic ref_bit,
    output logic aux_in
);
    // received stream is the reference with a bit flipped on request; gate level is registered
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_bit <= 1'b0;
            ref_bit <= 1'b0;
            aux_in <= 1'b0;
        end
        else
        begin
            ref_bit <= pat_bit;
            rx_bit <= pat_bit ^ err_req;
            aux_in <= aux_req;
        end
    end
endmodule

// ==== tb/test_bmg_gate.sv ====
// self-checking bench for the burst measurement gate
`timescale 1ns/1ps
`include "bmg_cfg.svh"
module test_bmg_gate;
    logic clk, reset_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic rx_bit, ref_bit, aux_in, cmp_en, err_pulse, pat_bit, err_req, aux_req, er;
    int failures, n_tests, cyc, n_cmp, rise_cyc, aux_cyc, lat0, exp_err;
    int n_err, base, base_err;
    logic cmp_prev;
    integer seed;
    bmg_gate dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_bit(rx_bit), .ref_bit(ref_bit), .aux_in(aux_in),
        .cmp_en(cmp_en), .err_pulse(err_pulse));
    bmg_far_end far (.clk(clk), .reset_n(reset_n), .pat_bit(pat_bit), .err_req(err_req),
        .aux_req(aux_req), .rx_bit(rx_bit), .ref_bit(ref_bit), .aux_in(aux_in));
    // 25 MHz bit clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task test_done;
        $display("compares %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task chk(input logic [34:0] got, input logic [34:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer; request held until pready is seen high at an edge
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk({3'h0, rd}, {3'h0, exp});
    endtask
    // gate window of w bits with errors every 50 bits; model counts the ones inside the gate
    task run_window(input int w, input int d);
        exp_err = 0;
        for (int i = 0; i < w + 200; i++)
        begin
            @(posedge clk);
            if (i == 0)
                aux_cyc = cyc;
            aux_req <= (i < w);
            err_req <= (i % 50 == 20);
            if (i % 50 == 20 && i >= d && i < d + w)
                exp_err++;
        end
        err_req <= 1'b0;
    endtask
    // monitor: cycle count, random pattern, gate statistics and hang limit
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        pat_bit <= 1'($random(seed));
        if (cmp_en === 1'b1)
            n_cmp <= n_cmp + 1;
        if (err_pulse === 1'b1)
            n_err <= n_err + 1;
        if (cmp_en === 1'b1 && cmp_prev !== 1'b1)
            rise_cyc <= cyc;
        cmp_prev <= cmp_en;
        if (cyc > 90000)
        begin
            failures++;
            test_done;
        end
    end
    initial
    begin
        seed = 32'h9fd46dfc;
        {reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {pat_bit, err_req, aux_req, cmp_prev} = '0;
        {failures, n_tests, cyc, n_cmp, rise_cyc, aux_cyc, lat0, n_err} = '0;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        // reset values, then an unmapped and an unaligned access
        rd_chk(`BMG_OFS_CTRL, 32'h0);
        rd_chk(`BMG_OFS_EN, 32'd100);
        rd_chk(`BMG_OFS_CYC, 32'd200);
        rd_chk(`BMG_OFS_DLY, 32'h0);
        apb(1'b0, 8'h1c, 32'h0);
        chk({34'h0, er}, 35'h1);
        chk({3'h0, rd}, 35'h0);
        apb(1'b1, 8'h02, 32'hffffffff);
        chk({34'h0, er}, 35'h1);
        rd_chk(`BMG_OFS_CTRL, 32'h0);
        apb(1'b1, `BMG_OFS_EN, 32'd120);
        rd_chk(`BMG_OFS_EN, 32'd120);
        apb(1'b1, `BMG_OFS_EN, 32'd100);
        // repeat mode compares everything
        for (int i = 0; i < 30; i++)
        begin
            @(posedge clk);
            err_req <= (i % 10 == 5);
        end
        err_req <= 1'b0;
        repeat (8) @(posedge clk);
        rd_chk(`BMG_OFS_ERR, 32'd3);
        chk({34'h0, cmp_en}, 35'h1);
        // burst with external enable: listed patterns gate, others behave as repeat
        for (int p = 0; p < 5; p++)
        begin
            apb(1'b1, `BMG_OFS_CTRL, 32'h5 | (p << 6));
            repeat (8) @(posedge clk);
            chk({34'h0, cmp_en}, {34'h0, p > 3});
        end
        // external enable window, automatic one slot, then manual 2 steps of 64 bits, four slots
        for (int m = 0; m < 2; m++)
        begin
            apb(1'b1, `BMG_OFS_CTRL, 32'h5 | (m << 3) | (m << 5));
            apb(1'b1, `BMG_OFS_DLY, 32'h2 * m);
            repeat (10) @(posedge clk);
            apb(1'b1, `BMG_OFS_ERR, 32'h0);
            base = n_cmp;
            base_err = n_err;
            run_window(200, 128 * m);
            rd_chk(`BMG_OFS_ERR, 32'(exp_err));
            rd_chk(`BMG_OFS_BITS, 32'd200);
            chk(35'(n_cmp - base), 35'd200);
            chk(35'(n_err - base_err), 35'(exp_err));
            if (m == 0)
                lat0 = rise_cyc - aux_cyc;
            else
                chk(35'(rise_cyc - aux_cyc - lat0), 35'd128);
        end
        // external trigger, two slots: 100 steps of 256 bits; a second trigger is ignored
        apb(1'b1, `BMG_OFS_CTRL, 32'h13);
        repeat (10) @(posedge clk);
        base = n_cmp;
        for (int i = 0; i < 28000; i++)
        begin
            @(posedge clk);
            aux_req <= (i < 3) || (i >= 2000 && i < 2003);
        end
        chk(35'(n_cmp - base), 35'd25600);
        // internal, one slot: over one full cycle the gate is open 12800 of 25600 bits
        apb(1'b1, `BMG_OFS_CTRL, 32'h1);
        repeat (30) @(posedge clk);
        base = n_cmp;
        repeat (25600) @(posedge clk);
        chk(35'(n_cmp - base), 35'd12800);
        test_done;
    end
endmodule
